// ### core/adc_defs.vh
// constants shared by the converter sequencer files
// Notes on behaviour
// R01: eight analog channels are offered and each conversion yields an 8-bit code.
// R02: conversion runs by successive approximation; the code lands in a readable register.
// R03: exactly one channel, picked by software, feeds each conversion.
// R04: a rising level on the trigger pin starts one conversion; the source drives it.
// R05: software setting the start bit of the mode register begins converting.
// R06: a pin-started conversion stops when finished and waits for the next start.
// R07: a software start converts over and over on the chosen channel.
// R08: every finished software-started conversion raises the completion interrupt once.
// R09: the result register holds the new code no later than the interrupt.
`ifndef ADC_DEFS_VH
`define ADC_DEFS_VH

// register byte offsets
`define ADC_OFS_MODE        8'h00
`define ADC_OFS_RESULT      8'h04
`define ADC_OFS_IRQ_STATUS  8'h08
`define ADC_OFS_IRQ_MASK    8'h0C
`define ADC_OFS_STATE       8'h10

// mode register fields
`define ADC_MODE_START_BIT  0
`define ADC_MODE_HWEN_BIT   1
`define ADC_MODE_CH_LSB     4
`define ADC_MODE_CH_MSB     6

// interrupt status and mask fields
`define ADC_IRQ_SW_DONE_BIT 0
`define ADC_IRQ_HW_DONE_BIT 1
`define ADC_IRQ_WIDTH       2

// state register fields
`define ADC_STATE_BUSY_BIT  0
`define ADC_STATE_RUN_BIT   1
`define ADC_STATE_HWPND_BIT 2

// reset values
`define ADC_RST_CHANNEL     3'h0
`define ADC_RST_RESULT      8'h00
`define ADC_RST_IRQ         2'h0

// timing: sample-and-hold window before the bit trials
`define ADC_CLK_MHZ         25
`define ADC_SAMPLE_TIME_NS  1000
`define ADC_SAMPLE_CYCLES   ((`ADC_SAMPLE_TIME_NS * `ADC_CLK_MHZ + 999) / 1000)

`endif

// ### core/trigger_edge.v
// rising-edge detector for synchronous level inputs
`timescale 1ns/1ps
module trigger_edge #(
    parameter WIDTH = 1
) (
    input  wire             clk_sys,
    input  wire             reset,
    input  wire [WIDTH-1:0] level_in,
    output wire [WIDTH-1:0] rise_pulse
);
    reg [WIDTH-1:0] prev_ff;

    // held high at reset so a pin already high does not fire on release
    always @(posedge clk_sys) begin
        if (reset) begin
            prev_ff <= {WIDTH{1'b1}};
        end else begin
            prev_ff <= level_in;
        end
    end

    assign rise_pulse = level_in & ~prev_ff;
endmodule // trigger_edge

// ### core/sar_engine.v
// successive approximation engine: sample window then one bit trial per clock
`timescale 1ns/1ps
module sar_engine #(
    parameter WIDTH         = 8,
    parameter CH_WIDTH      = 3,
    parameter SAMPLE_CYCLES = 25
) (
    input  wire                clk_sys,
    input  wire                reset,
    input  wire                start,
    input  wire [CH_WIDTH-1:0] channel,
    input  wire                comparator_in,
    output reg  [CH_WIDTH-1:0] channel_ff,
    output reg  [WIDTH-1:0]    trial_ff,
    output reg                 sample_ff,
    output reg                 busy_ff,
    output reg                 done_ff,
    output reg  [WIDTH-1:0]    result_ff
);
    localparam ST_IDLE    = 3'b001;
    localparam ST_SAMPLE  = 3'b010;
    localparam ST_CONVERT = 3'b100;
    localparam integer SAMPLE_LAST_INT = SAMPLE_CYCLES - 1;
    localparam [15:0]  SAMPLE_LAST     = SAMPLE_LAST_INT[15:0];

    reg [2:0]       state_ff;
    reg [15:0]      count_ff;
    reg [WIDTH-1:0] bit_ff;
    wire [WIDTH-1:0] kept = comparator_in ? trial_ff : (trial_ff & ~bit_ff);

    always @(posedge clk_sys) begin
        if (reset) begin
            state_ff   <= ST_IDLE;
            count_ff   <= 16'h0000;
            bit_ff     <= {WIDTH{1'b0}};
            channel_ff <= {CH_WIDTH{1'b0}};
            trial_ff   <= {WIDTH{1'b0}};
            sample_ff  <= 1'b0;
            busy_ff    <= 1'b0;
            done_ff    <= 1'b0;
            result_ff  <= {WIDTH{1'b0}};
        end else begin
            done_ff <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    if (start) begin
                        channel_ff <= channel; // R03
                        count_ff   <= 16'h0000;
                        sample_ff  <= 1'b1;
                        busy_ff    <= 1'b1;
                        state_ff   <= ST_SAMPLE;
                    end
                end
                ST_SAMPLE: begin
                    if (count_ff == SAMPLE_LAST) begin
                        sample_ff <= 1'b0;
                        bit_ff    <= {1'b1, {(WIDTH-1){1'b0}}};
                        trial_ff  <= {1'b1, {(WIDTH-1){1'b0}}};
                        state_ff  <= ST_CONVERT;
                    end else begin
                        count_ff <= count_ff + 16'h0001;
                    end
                end
                ST_CONVERT: begin
                    // comparator must settle on trial_ff within one clock
                    if (bit_ff[0]) begin
                        result_ff <= kept; // R02
                        trial_ff  <= kept;
                        done_ff   <= 1'b1;
                        busy_ff   <= 1'b0;
                        state_ff  <= ST_IDLE;
                    end else begin
                        trial_ff <= kept | (bit_ff >> 1); // R02
                        bit_ff   <= bit_ff >> 1;
                    end
                end
                default: begin
                    state_ff  <= ST_IDLE;
                    sample_ff <= 1'b0;
                    busy_ff   <= 1'b0;
                end
            endcase
        end
    end
endmodule // sar_engine

// ### core/adc_sequencer_8ch.v
// converter sequencer top: wishbone registers, start control and completion interrupt
`timescale 1ns/1ps
`include "adc_defs.vh"
module adc_sequencer_8ch #(
    parameter RES_BITS      = 8,
    parameter CHANNELS      = 8,
    parameter SAMPLE_CYCLES = `ADC_SAMPLE_CYCLES
) (
    input  wire        clk_sys,
    input  wire        reset,
    // wishbone classic slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // trigger and analog front end
    input  wire        hw_trigger_pin,
    input  wire        comparator_in,
    output wire [2:0]  analog_input_sel,
    output wire [7:0]  dac_trial,
    output wire        sample_hold,
    output reg         conversion_done_irq
);
    // channel 0 is analog_input_first, channel 7 analog_input_last
    localparam CH_WIDTH = 3;

    // mode register state
    reg                      run_ff;
    reg                      hw_en_ff;
    reg  [CH_WIDTH-1:0]      channel_ff;
    reg                      hw_pend_ff;
    reg                      hw_origin_ff;
    reg  [`ADC_IRQ_WIDTH-1:0] irq_status_ff;
    reg  [`ADC_IRQ_WIDTH-1:0] irq_mask_ff;

    reg                      nxt_run;
    reg                      nxt_hw_en;
    reg  [CH_WIDTH-1:0]      nxt_channel;
    reg                      nxt_hw_pend;
    reg                      nxt_hw_origin;
    reg  [`ADC_IRQ_WIDTH-1:0] nxt_irq_status;
    reg  [`ADC_IRQ_WIDTH-1:0] nxt_irq_mask;
    reg  [31:0]              nxt_rdata;

    wire                     eng_busy;
    wire                     eng_done;
    wire [RES_BITS-1:0]      eng_result;
    wire                     trig_rise;
    wire                     eng_start;

    // bus decode: the write lands on the edge that samples ack, so it acts once
    wire bus_req   = wb_cyc_i & wb_stb_i;
    wire wr_commit = bus_req & wb_we_i & wb_ack_o;
    wire wr_mode   = wr_commit & (wb_adr_i == `ADC_OFS_MODE);
    wire wr_status = wr_commit & (wb_adr_i == `ADC_OFS_IRQ_STATUS);
    wire wr_mask   = wr_commit & (wb_adr_i == `ADC_OFS_IRQ_MASK);

    trigger_edge #(
        .WIDTH      (1)
    ) u_trigger_edge (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .level_in   (hw_trigger_pin),
        .rise_pulse (trig_rise)
    );

    // software run has priority and its start clears a pending pin start; with run off, a pending pin start goes when idle
    assign eng_start = ~eng_busy & (run_ff | hw_pend_ff); // R04 R05 R07

    sar_engine #(
        .WIDTH         (RES_BITS),
        .CH_WIDTH      (CH_WIDTH),
        .SAMPLE_CYCLES (SAMPLE_CYCLES)
    ) u_sar_engine (
        .clk_sys       (clk_sys),
        .reset         (reset),
        .start         (eng_start),
        .channel       (channel_ff),
        .comparator_in (comparator_in),
        .channel_ff    (analog_input_sel),
        .trial_ff      (dac_trial),
        .sample_ff     (sample_hold),
        .busy_ff       (eng_busy),
        .done_ff       (eng_done),
        .result_ff     (eng_result)
    );

    // control and mode register
    always @* begin
        nxt_run       = run_ff;
        nxt_hw_en     = hw_en_ff;
        nxt_channel   = channel_ff;
        nxt_hw_pend   = hw_pend_ff;
        nxt_hw_origin = hw_origin_ff;
        if (wr_mode && wb_sel_i[0]) begin
            nxt_run     = wb_dat_i[`ADC_MODE_START_BIT]; // R05
            nxt_hw_en   = wb_dat_i[`ADC_MODE_HWEN_BIT];
            nxt_channel = wb_dat_i[`ADC_MODE_CH_MSB:`ADC_MODE_CH_LSB]; // R03
        end
        // the pin only arms a start; a busy engine or a running loop absorbs it
        if (trig_rise && hw_en_ff && !run_ff && !eng_busy) begin
            nxt_hw_pend = 1'b1; // R04
        end
        if (eng_start) begin
            nxt_hw_origin = ~run_ff;
            nxt_hw_pend   = 1'b0; // R06
        end
    end

    // sticky completion flags: a new event wins over a clear in the same cycle
    always @* begin
        nxt_irq_status = irq_status_ff;
        nxt_irq_mask   = irq_mask_ff;
        if (wr_status && wb_sel_i[0]) begin
            nxt_irq_status = irq_status_ff & ~wb_dat_i[`ADC_IRQ_WIDTH-1:0];
        end
        if (wr_mask && wb_sel_i[0]) begin
            nxt_irq_mask = wb_dat_i[`ADC_IRQ_WIDTH-1:0];
        end
        if (eng_done && !hw_origin_ff) begin
            nxt_irq_status[`ADC_IRQ_SW_DONE_BIT] = 1'b1; // R08
        end
        if (eng_done && hw_origin_ff) begin
            nxt_irq_status[`ADC_IRQ_HW_DONE_BIT] = 1'b1;
        end
    end

    // read mux; unmapped offsets read as zero
    always @* begin
        nxt_rdata = 32'h0000_0000;
        case (wb_adr_i)
            `ADC_OFS_MODE: begin
                nxt_rdata[`ADC_MODE_START_BIT]               = run_ff;
                nxt_rdata[`ADC_MODE_HWEN_BIT]                = hw_en_ff;
                nxt_rdata[`ADC_MODE_CH_MSB:`ADC_MODE_CH_LSB] = channel_ff;
            end
            `ADC_OFS_RESULT: begin
                nxt_rdata[RES_BITS-1:0] = eng_result; // R01 R02
            end
            `ADC_OFS_IRQ_STATUS: begin
                nxt_rdata[`ADC_IRQ_WIDTH-1:0] = irq_status_ff;
            end
            `ADC_OFS_IRQ_MASK: begin
                nxt_rdata[`ADC_IRQ_WIDTH-1:0] = irq_mask_ff;
            end
            `ADC_OFS_STATE: begin
                nxt_rdata[`ADC_STATE_BUSY_BIT]  = eng_busy;
                nxt_rdata[`ADC_STATE_RUN_BIT]   = run_ff;
                nxt_rdata[`ADC_STATE_HWPND_BIT] = hw_pend_ff;
            end
            default: begin
                nxt_rdata = 32'h0000_0000;
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            run_ff              <= 1'b0;
            hw_en_ff            <= 1'b0;
            channel_ff          <= `ADC_RST_CHANNEL;
            hw_pend_ff          <= 1'b0;
            hw_origin_ff        <= 1'b0;
            irq_status_ff       <= `ADC_RST_IRQ;
            irq_mask_ff         <= `ADC_RST_IRQ;
            conversion_done_irq <= 1'b0;
            wb_ack_o            <= 1'b0;
            wb_dat_o            <= 32'h0000_0000;
        end else begin
            run_ff              <= nxt_run;
            hw_en_ff            <= nxt_hw_en;
            channel_ff          <= nxt_channel;
            hw_pend_ff          <= nxt_hw_pend;
            hw_origin_ff        <= nxt_hw_origin;
            irq_status_ff       <= nxt_irq_status;
            irq_mask_ff         <= nxt_irq_mask;
            // taken from next values so the line rises with its status bit
            conversion_done_irq <= |(nxt_irq_status & nxt_irq_mask); // R08 R09
            // one wait state, ack dropped the cycle after it is given
            wb_ack_o            <= bus_req & ~wb_ack_o;
            if (bus_req && !wb_ack_o) begin
                wb_dat_o <= nxt_rdata;
            end
        end
    end
endmodule // adc_sequencer_8ch

// ### dv/adc_properties.sv
// port-level checks for the converter sequencer
`timescale 1ns/1ps
module adc_properties #(
    parameter SAMPLE_CYCLES = 25
) (
    input wire        clk_sys,
    input wire        reset,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire [2:0]  analog_input_sel,
    input wire        sample_hold,
    input wire        conversion_done_irq
);
    reg [15:0] hold_ff;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // length of the open sample window, so its close can be checked exactly
    always @(posedge clk_sys) begin
        if (reset || !sample_hold)
            hold_ff <= 16'h0000;
        else
            hold_ff <= hold_ff + 16'h0001;
    end
    ack_one_wait_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    ack_needs_req_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h10 |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    sample_len_a: assert property ($fell(sample_hold) |-> hold_ff == SAMPLE_CYCLES)
        else $error("sample window length wrong");
    trial_gap_a: assert property ($fell(sample_hold) |-> !sample_hold [*8])
        else $error("bit trials cut short");
    sel_steady_a: assert property (sample_hold |=> $stable(analog_input_sel))
        else $error("channel changed mid conversion");
    reset_quiet_a: assert property (disable iff (1'b0) reset |=> !wb_ack_o && !conversion_done_irq && !sample_hold)
        else $error("outputs active after reset");
    cover property ($rose(conversion_done_irq));
    cover property ($fell(sample_hold));
    cover property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h10);
endmodule // adc_properties

bind adc_sequencer_8ch adc_properties #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) chk_u (
    .clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .analog_input_sel(analog_input_sel),
    .sample_hold(sample_hold), .conversion_done_irq(conversion_done_irq));

// ### dv/analog_source_model.sv
// analog inputs and comparator: one fixed level per channel
`timescale 1ns/1ps
module analog_source_model (
    input  wire [63:0] levels,
    input  wire [2:0]  analog_input_sel,
    input  wire [7:0]  dac_trial,
    output wire        comparator_in
);
    // ideal comparator, so a good conversion returns the level exactly
    assign comparator_in = levels[{analog_input_sel, 3'b000} +: 8] >= dac_trial;
endmodule // analog_source_model

// ### dv/tb.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked = checked + 1; if ((g) !== (e)) begin mismatches = mismatches + 1; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tb;
    reg         clk_sys = 1'b0;
    reg         reset   = 1'b1;
    reg         wb_cyc  = 1'b0;
    reg         wb_stb  = 1'b0;
    reg         wb_we   = 1'b0;
    reg  [7:0]  wb_adr  = 8'h00;
    reg  [31:0] wb_dat  = 32'h0;
    reg  [3:0]  wb_sel  = 4'hF;
    reg         trig    = 1'b0;
    reg  [63:0] levels  = 64'hFF_B4_96_5A_3C_A5_01_00;
    wire [31:0] wb_dat_o;
    wire        wb_ack_o;
    wire        comp;
    wire [2:0]  sel;
    wire [7:0]  trial;
    wire        sample_hold;
    wire        irq;
    integer     mismatches = 0;
    integer     checked = 0;
    integer     i;
    reg  [31:0] d;
    always #20 clk_sys = ~clk_sys;
    adc_sequencer_8ch #(.SAMPLE_CYCLES(2)) dut_u (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .hw_trigger_pin(trig), .comparator_in(comp),
        .analog_input_sel(sel), .dac_trial(trial), .sample_hold(sample_hold), .conversion_done_irq(irq));
    analog_source_model src_u (.levels(levels), .analog_input_sel(sel), .dac_trial(trial), .comparator_in(comp));
    task complete_run;
        begin
            if (mismatches == 0 && checked > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    // one classic cycle; the extra edge keeps cyc low a cycle between requests
    task bus(input [7:0] a, input w, input [31:0] v);
        integer n;
        begin
            n = 0;
            wb_cyc <= 1'b1;
            wb_stb <= 1'b1;
            wb_we <= w;
            wb_adr <= a;
            wb_dat <= v;
            @(posedge clk_sys);
            while (wb_ack_o !== 1'b1 && n < 20) begin
                @(posedge clk_sys);
                n = n + 1;
            end
            if (n == 20)
                mismatches = mismatches + 1;
            d = wb_dat_o;
            wb_cyc <= 1'b0;
            wb_stb <= 1'b0;
            @(posedge clk_sys);
        end
    endtask
    task wait_irq;
        integer n;
        begin
            n = 0;
            while (irq !== 1'b1 && n < 200) begin
                @(posedge clk_sys);
                n = n + 1;
            end
            `CHK("irq", 1'b1, irq)
        end
    endtask
    task pulse_trig;
        begin
            trig <= 1'b1;
            @(posedge clk_sys);
            trig <= 1'b0;
        end
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        bus(8'h04, 1'b1, 32'hFF);
        for (i = 0; i < 6; i = i + 1) begin
            bus(8'(i * 4), 1'b0, 32'h0);
            `CHK("reset value", 32'h0, d)
        end
        // a write with byte lane 0 disabled must leave the mode register alone
        wb_sel <= 4'h0;
        bus(8'h00, 1'b1, 32'h73);
        wb_sel <= 4'hF;
        bus(8'h00, 1'b0, 32'h0);
        `CHK("mode sel gated", 32'h0, d)
        bus(8'h0C, 1'b1, 32'h3);
        for (i = 0; i < 8; i = i + 1) begin
            bus(8'h00, 1'b1, {25'h0, i[2:0], 4'h2});
            pulse_trig;
            wait_irq;
            `CHK("channel", i[2:0], sel)
            `CHK("trial", levels[i*8 +: 8], trial)
            bus(8'h04, 1'b0, 32'h0);
            `CHK("result", {24'h0, levels[i*8 +: 8]}, d)
            bus(8'h08, 1'b1, 32'h2);
            repeat (30) @(posedge clk_sys);
            bus(8'h08, 1'b0, 32'h0);
            `CHK("hw stop", 32'h0, d)
        end
        bus(8'h0C, 1'b1, 32'h1);
        pulse_trig;
        repeat (20) @(posedge clk_sys);
        `CHK("masked irq", 1'b0, irq)
        bus(8'h0C, 1'b1, 32'h2);
        `CHK("unmasked irq", 1'b1, irq)
        bus(8'h08, 1'b1, 32'h2);
        bus(8'h0C, 1'b1, 32'h1);
        bus(8'h00, 1'b1, 32'h21);
        bus(8'h10, 1'b0, 32'h0);
        `CHK("run bit", 1'b1, d[1])
        for (i = 0; i < 3; i = i + 1) begin
            wait_irq;
            bus(8'h04, 1'b0, 32'h0);
            `CHK("repeat result", 32'hA5, d)
            bus(8'h08, 1'b1, 32'h1);
        end
        bus(8'h00, 1'b1, 32'h0);
        repeat (20) @(posedge clk_sys);
        bus(8'h08, 1'b1, 32'h1);
        // trigger enable is off now, so this pin edge must be refused
        pulse_trig;
        repeat (20) @(posedge clk_sys);
        bus(8'h08, 1'b0, 32'h0);
        `CHK("run stopped", 32'h0, d)
        complete_run;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches = mismatches + 1;
        complete_run;
    end
endmodule // tb
